/* hw/scsc_pkg.sv */
package scsc_pkg;

  // Register bus addresses and field positions.
  localparam logic [7:0] SC1_ADDR     = 8'h38;
  localparam logic [7:0] SC2_ADDR     = 8'h39;
  localparam int         SC1_STOP_BIT = 7;
  localparam int         SC1_STOP_RELEASE_SELECT_BIT = 6;
  localparam int         SC1_ONE_BIT  = 4;
  localparam int         SC1_WUT_HI   = 3;
  localparam int         SC1_WUT_LO   = 2;
  localparam int         SC2_IDLE_BIT = 4;
  localparam logic [7:0] SC2_FIXED    = 8'h80;

  // Reset values of the control fields.
  localparam logic       STOP_RST = 1'b0;
  localparam logic       STOP_RELEASE_SELECT_RST = 1'b0;
  localparam logic       ONE_RST  = 1'b0;
  localparam logic [1:0] WUT_RST  = 2'h0;
  localparam logic       IDLE_RST = 1'b0;

  // Warm-up selection codes.
  localparam logic [1:0] WUT_LONG  = 2'h0;
  localparam logic [1:0] WUT_SHORT = 2'h1;

  // Timing: the clock is the high frequency clock itself.
  localparam int CLK_PERIOD_NS = 100;
  localparam int DIV_STAGES    = 21;
  localparam int PRE_MOD       = 3;
  localparam int WARM_W        = 18;

  // Machine cycle states, one clock each.
  localparam logic [1:0] ST_S0 = 2'h0;
  localparam logic [1:0] ST_S3 = 2'h3;
  localparam logic [1:0] PRE_LAST = 2'(PRE_MOD - 1);

  // Divider tap indices for the derived source clocks.
  localparam int TAP_TB  = 13;
  localparam int TAP_WDT = 15;
  localparam int TAP_TC0 = 1;
  localparam int TAP_RST = 17;
  localparam int TAP_TC_STEP = 2;

  typedef enum logic [3:0]
  {
    SCSC_NORMAL = 4'h1,
    SCSC_IDLE   = 4'h2,
    SCSC_STOP   = 4'h4,
    SCSC_WARM   = 4'h8
  } scsc_mode_e;

  // High when stage idx of the divider turns from low to high on a count.
  function automatic logic scsc_tap_rise(input logic [20:0] d,
                                         input int          idx);
    logic r;
    r = 1'b1;
    for (int i = 0; i < DIV_STAGES; i++)
    begin
      if (i < idx)
      begin
        r = r & d[i];
      end
    end
    return r & ~d[idx];
  endfunction : scsc_tap_rise

endpackage : scsc_pkg

/* hw/scsc_divider.sv */
`timescale 1ns/1ps
module scsc_divider
  import scsc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        run_in,
  input  wire logic        clear_in,
  input  wire logic        tick_in,
  output logic [20:0]      div_out,
  output logic             pre_tick_out
);

  logic [1:0]  pre_reg;
  logic [1:0]  pre_next;
  logic [20:0] div_reg;
  logic [20:0] div_next;

  // The prescaler is left alone by a stop release; only reset clears it.
  assign pre_next = (pre_reg == PRE_LAST) ? 2'h0 : pre_reg + 2'h1; // R1
  // Stage one counts machine cycles, so stage seven sees fc over 256.
  assign div_next = clear_in ? 21'h0 :                             // R2
                    (tick_in ? div_reg + 21'h1 : div_reg);         // R3

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pre_reg <= 2'h0;
      div_reg <= 21'h0;
    end
    else
    begin
      if (run_in)
      begin
        pre_reg <= pre_next;
      end
      div_reg <= div_next;
    end
  end

  assign div_out      = div_reg;
  assign pre_tick_out = run_in && (pre_reg == PRE_LAST);

endmodule : scsc_divider

/* hw/scsc_clock_ctrl.sv */
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
// Function
// R1 - Prescaler divides by three; a 21-stage divider counts machine cycles.
// R2 - Divider clears to zero at reset and on stop release.
// R3 - Seventh divider stage receives the clock divided by 256.
// R4 - Divider taps feed time base, watchdog, timers, warm-up and reset; here the warm-up counts on its own counter warm_reg instead.
// R5 - A machine cycle is four states, each one clock long.
// R6 - Instructions last one to fifteen machine cycles.
// R7 - One machine cycle equals four high frequency clock periods.
// R8 - Normal mode clocks core and peripherals from the fast clock.
// R9 - Idle stops core and watchdog clocks, peripherals keep running.
// R10 - Writing one to the idle bit enters idle mode.
// R11 - Any interrupt request returns idle to normal mode.
// R12 - With master enable set, the interrupt is taken on wake.
// R13 - With master enable clear, the next instruction resumes on wake.
// R14 - Stop bit set halts oscillator and all internal operation.
// R15 - Release select picks level-high or rising-edge stop release.
// R16 - The core clock restarts at state zero on a cycle boundary.
module scsc_clock_ctrl
  import scsc_pkg::*;
#(
  parameter int WARM_LONG_CYC  = 196608,
  parameter int WARM_SHORT_CYC = 65536
)
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [7:0]       rdata_out,
  input  wire logic        irq_req_in,
  input  wire logic        ime_in,
  input  wire logic [3:0]  instr_len_in,
  input  wire logic        stop_pin_in,
  output logic             cpu_run_out,
  output logic [1:0]       cpu_state_out,
  output logic             instr_done_out,
  output logic             periph_run_out,
  output logic             wdt_run_out,
  output logic             osc_run_out,
  output logic             take_irq_out,
  output logic             resume_next_out,
  output logic             pre_tick_out,
  output logic             tb_src_out,
  output logic             wdt_src_out,
  output logic [3:0]       tc_src_out,
  output logic             reset_done_out
);

  scsc_mode_e       mode_reg;
  scsc_mode_e       mode_next;
  logic [1:0]       st_reg;
  logic             stop_reg;
  logic             stop_release_select_reg;
  logic             one_reg;
  logic [1:0]       wut_reg;
  logic             idle_reg;
  logic             wake_reg;
  logic             pin_prev_reg;
  logic [WARM_W-1:0] warm_reg;
  logic [3:0]       mc_left_reg;
  logic             mc_busy_reg;
  logic             done_reg;
  logic             take_reg;
  logic             resume_reg;
  logic             rst_done_reg;
  logic [7:0]       rdata_reg;
  logic [20:0]      div;
  logic             div_tick;

  // Register decode and the read image of both control registers.
  wire wr_sc1 = wr_in && (addr_in == SC1_ADDR);
  wire wr_sc2 = wr_in && (addr_in == SC2_ADDR);
  wire [7:0] sc1_img = {stop_reg, stop_release_select_reg, 1'b0, one_reg,
                        wut_reg, 2'h0};
  wire [7:0] sc2_img = SC2_FIXED | {3'h0, idle_reg, 4'h0};
  wire [7:0] rd_mux  = (addr_in == SC1_ADDR) ? sc1_img :
                       (addr_in == SC2_ADDR) ? sc2_img : 8'h00;

  // Mode decode and machine cycle boundary.
  wire is_normal = (mode_reg == SCSC_NORMAL);
  wire is_idle   = (mode_reg == SCSC_IDLE);
  wire is_stop   = (mode_reg == SCSC_STOP);
  wire at_s3     = (st_reg == ST_S3);
  wire at_s0     = (st_reg == ST_S0);

  // Stop release: level mode needs the pin high, edge mode a rising edge.
  wire pin_rise  = stop_pin_in && !pin_prev_reg;
  wire stop_rel  = is_stop && (stop_release_select_reg ? stop_pin_in : pin_rise); // R15
  wire idle_go   = is_normal && !stop_reg && idle_reg && at_s3;    // R10
  // Waking only at S3 keeps the first restarted state a clean S0.
  wire idle_exit = is_idle && (wake_reg || irq_req_in) && at_s3;  // R16
  wire warm_end  = (mode_reg == SCSC_WARM) && (warm_reg == '0);
  wire cpu_start = cpu_run_out && at_s0 && !mc_busy_reg;
  wire [3:0] len_eff = (instr_len_in == 4'h0) ? 4'h1 : instr_len_in;

  // Warm-up length; the reserved codes fall back to the long count.
  wire [WARM_W-1:0] warm_load = (wut_reg == WUT_SHORT) ?
                                WARM_W'(WARM_SHORT_CYC - 1) :
                                WARM_W'(WARM_LONG_CYC - 1);

  // Next mode: stop takes precedence over an idle request.
  always_comb
  begin
    mode_next = mode_reg;
    case (mode_reg)
      SCSC_NORMAL:
        if (stop_reg)
          mode_next = SCSC_STOP; // R14
        else if (idle_go)
          mode_next = SCSC_IDLE; // R10
      SCSC_IDLE:
        if (idle_exit)
          mode_next = SCSC_NORMAL; // R11
      SCSC_STOP:
        if (stop_rel)
          mode_next = SCSC_WARM;
      SCSC_WARM:
        if (warm_end)
          mode_next = SCSC_NORMAL;
      default:
        mode_next = SCSC_NORMAL;
    endcase
  end

  // Mode register and machine state counter.
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      mode_reg <= SCSC_NORMAL;
      st_reg   <= ST_S0;
    end
    else
    begin
      mode_reg <= mode_next;
      if (stop_rel)
        st_reg <= ST_S0;
      else if (!is_stop)
        st_reg <= st_reg + 2'h1; // R5 R7
    end
  end

  // Control register fields; hardware clears stop and idle when done.
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      stop_reg <= STOP_RST;
      stop_release_select_reg <= STOP_RELEASE_SELECT_RST;
      one_reg  <= ONE_RST;
      wut_reg  <= WUT_RST;
      idle_reg <= IDLE_RST;
    end
    else
    begin
      if (wr_sc1)
      begin
        stop_reg <= wdata_in[SC1_STOP_BIT]; // R14
        stop_release_select_reg <= wdata_in[SC1_STOP_RELEASE_SELECT_BIT];
        one_reg  <= wdata_in[SC1_ONE_BIT];
        wut_reg  <= wdata_in[SC1_WUT_HI:SC1_WUT_LO];
      end
      else if (warm_end)
        stop_reg <= 1'b0;
      if (wr_sc2)
      begin
        idle_reg <= wdata_in[SC2_IDLE_BIT]; // R10
      end
      else if (idle_exit)
        idle_reg <= 1'b0;
    end
  end

  // A request seen during idle is held so it is not lost before S3.
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wake_reg     <= 1'b0;
      pin_prev_reg <= 1'b0;
      warm_reg     <= '0;
    end
    else
    begin
      wake_reg     <= is_idle && !idle_exit && (wake_reg || irq_req_in);
      pin_prev_reg <= stop_pin_in;
      if (stop_rel)
      begin
        warm_reg <= warm_load;
      end
      else if (!warm_end && (mode_reg == SCSC_WARM))
      begin
        warm_reg <= warm_reg - WARM_W'(1);
      end
    end
  end

  // Instruction length counter in machine cycles.
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      mc_left_reg <= 4'h0;
      mc_busy_reg <= 1'b0;
      done_reg    <= 1'b0;
    end
    else
    begin
      done_reg <= cpu_run_out && at_s3 && mc_busy_reg &&
                  (mc_left_reg == 4'h0);
      if (cpu_start)
      begin
        mc_left_reg <= len_eff - 4'h1; // R6
        mc_busy_reg <= 1'b1;
      end
      else if (cpu_run_out && at_s3 && mc_busy_reg)
      begin
        if (mc_left_reg == 4'h0)
        begin
          mc_busy_reg <= 1'b0;
        end
        else
        begin
          mc_left_reg <= mc_left_reg - 4'h1; // R6
        end
      end
    end
  end

  // Wake outcome pulses and read data, one cycle after their cause.
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      take_reg     <= 1'b0;
      resume_reg   <= 1'b0;
      rst_done_reg <= 1'b0;
      rdata_reg    <= 8'h00;
    end
    else
    begin
      take_reg   <= idle_exit && ime_in;  // R12
      resume_reg <= idle_exit && !ime_in; // R13
      if (div_tick && scsc_tap_rise(div, TAP_RST))
      begin
        rst_done_reg <= 1'b1; // R4
      end
      rdata_reg <= rd_in ? rd_mux : 8'h00;
    end
  end

  // The divider advances once per machine cycle while the oscillator runs.
  assign div_tick = !is_stop && at_s3; // R1 R3

  scsc_divider scsc_divider_i
  (
    .clk_in       (clk_in),
    .rstn_in      (rstn_in),
    .run_in       (!is_stop),
    .clear_in     (stop_rel),
    .tick_in      (div_tick),
    .div_out      (div),
    .pre_tick_out (pre_tick_out)
  );

  // Source clocks for peripherals; the watchdog one stops outside normal.
  assign tb_src_out  = div_tick && scsc_tap_rise(div, TAP_TB);    // R4
  assign wdt_src_out = is_normal && div_tick &&
                       scsc_tap_rise(div, TAP_WDT);               // R9
  for (genvar g = 0; g < 4; g++)
  begin : g_tc
    assign tc_src_out[g] = periph_run_out && div_tick &&
                           scsc_tap_rise(div, TAP_TC0 + g * TAP_TC_STEP);
  end

  // Clock enables per mode.
  assign cpu_run_out     = is_normal;                             // R8
  assign periph_run_out  = is_normal || is_idle;                  // R9
  assign wdt_run_out     = is_normal;                             // R9
  assign osc_run_out     = !is_stop;                              // R14
  assign cpu_state_out   = st_reg;
  assign instr_done_out  = done_reg;
  assign take_irq_out    = take_reg;
  assign resume_next_out = resume_reg;
  assign reset_done_out  = rst_done_reg;
  assign rdata_out       = rdata_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  chk_state_step: assert property ( // R5
    !is_stop |=> st_reg == 2'($past(st_reg) + 2'h1))
    else $error("State counter did not step");
  chk_div_count: assert property ( // R1
    (div_tick && !stop_rel) |=> div == 21'($past(div) + 21'h1))
    else $error("Divider did not count on S3");
  chk_div_clear: assert property ( // R2
    stop_rel |=> (div == 21'h0) && (st_reg == ST_S0))
    else $error("Divider not cleared on stop release");
  chk_idle_entry: assert property ( // R10
    idle_go |=> is_idle && !cpu_run_out)
    else $error("Idle not entered at cycle end");
  chk_idle_wake: assert property ( // R11
    (is_idle && irq_req_in) |-> ##[1:4] is_normal)
    else $error("Interrupt did not release idle");
  chk_idle_clocks: assert property ( // R9
    is_idle |-> !cpu_run_out && !wdt_run_out && periph_run_out)
    else $error("Wrong clock enables in idle");
  chk_resume_s0: assert property ( // R16
    $rose(cpu_run_out) |-> at_s0)
    else $error("Core clock restarted off S0");
  chk_wake_take: assert property ( // R12
    (idle_exit && ime_in) |=> take_irq_out && !resume_next_out)
    else $error("Interrupt not taken on wake");
  chk_wake_resume: assert property ( // R13
    (idle_exit && !ime_in) |=> resume_next_out && !take_irq_out)
    else $error("Next instruction not resumed");
  chk_stop_halt: assert property ( // R14
    is_stop |-> !osc_run_out && !cpu_run_out && !periph_run_out)
    else $error("Stop did not halt operation");
  chk_level_rel: assert property ( // R15
    (is_stop && stop_release_select_reg && stop_pin_in) |=> mode_reg == SCSC_WARM)
    else $error("Level release failed");
  chk_one_cycle: assert property ( // R6
    cpu_start && (len_eff == 4'h1) |-> ##3 at_s3 ##1 instr_done_out)
    else $error("One cycle instruction mis-timed");

  cov_idle_trip: cover property (idle_go ##[1:20] idle_exit);
  cov_stop_rel:  cover property (is_stop ##[1:50] warm_end);
  cov_instr:     cover property (instr_done_out);

endmodule : scsc_clock_ctrl

/* verif/scsc_irq_partner.sv */
`timescale 1ns/1ps
// Interrupt source on the far side of the stand-by controller.
// It holds its request until the controller reports the wake-up, because a
// real interrupt line only drops once the core has seen it.
module scsc_irq_partner
  import scsc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       raise_in,
  input  wire logic [3:0] delay_in,
  input  wire logic       take_irq_in,
  input  wire logic       resume_next_in,
  output logic            irq_req_out
);
  logic [3:0] wait_reg;
  logic       armed_reg;

  // A raise arms a countdown, so the request can come promptly or slowly.
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wait_reg    <= 4'h0;
      armed_reg   <= 1'b0;
      irq_req_out <= 1'b0;
    end
    else if (take_irq_in || resume_next_in)
    begin
      irq_req_out <= 1'b0;
    end
    else if (raise_in)
    begin
      armed_reg <= 1'b1;
      wait_reg  <= delay_in;
    end
    else if (armed_reg && wait_reg == 4'h0)
    begin
      armed_reg   <= 1'b0;
      irq_req_out <= 1'b1;
    end
    else if (armed_reg)
    begin
      wait_reg <= wait_reg - 4'h1;
    end
  end
endmodule : scsc_irq_partner

/* verif/scsc_clock_ctrl_tb_top.sv */
`timescale 1ns/1ps
module scsc_clock_ctrl_tb_top
  import scsc_pkg::*;
;
  localparam int WL = 40;
  localparam int WS = 20;
  logic       clk_in = 1'b0;
  logic       rstn_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_in = 1'b0;
  logic       rd_in = 1'b0;
  logic       ime_in = 1'b0;
  logic [3:0] len_in = 4'h0;
  logic       pin_in = 1'b0;
  logic       raise = 1'b0;
  logic [3:0] delay = 4'h0;
  wire  logic irq;
  logic [7:0] rdata_out;
  logic       cpu_run_out, instr_done_out, periph_run_out, wdt_run_out;
  logic       osc_run_out, take_irq_out, resume_next_out, pre_tick_out;
  logic [1:0] cpu_state_out;
  logic [3:0] tc_src_out;
  logic       tb_src_out, wdt_src_out, reset_done_out;
  logic [9:0] mon;
  int         errors = 0;
  int         tests_run = 0;
  int         n, m;
  logic [1:0] st;

  // Half period of 50 ns gives the 10 MHz clock.
  always #50 clk_in = ~clk_in;

  scsc_clock_ctrl #(.WARM_LONG_CYC(WL), .WARM_SHORT_CYC(WS))
  scsc_clock_ctrl_i (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .irq_req_in(irq), .ime_in(ime_in),
    .instr_len_in(len_in), .stop_pin_in(pin_in),
    .cpu_run_out(cpu_run_out), .cpu_state_out(cpu_state_out),
    .instr_done_out(instr_done_out), .periph_run_out(periph_run_out),
    .wdt_run_out(wdt_run_out), .osc_run_out(osc_run_out),
    .take_irq_out(take_irq_out), .resume_next_out(resume_next_out),
    .pre_tick_out(pre_tick_out), .tb_src_out(tb_src_out),
    .wdt_src_out(wdt_src_out), .tc_src_out(tc_src_out),
    .reset_done_out(reset_done_out));

  scsc_irq_partner scsc_irq_partner_i (.clk_in(clk_in), .rstn_in(rstn_in),
    .raise_in(raise), .delay_in(delay), .take_irq_in(take_irq_out),
    .resume_next_in(resume_next_out), .irq_req_out(irq));

  // Monitored events, looked up by index in the wait task.
  assign mon = {tb_src_out, pre_tick_out, ~osc_run_out, cpu_run_out,
                ~cpu_run_out, resume_next_out, take_irq_out,
                instr_done_out, tc_src_out[1:0]};

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample there.
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out, exp);
  endtask : rd

  // Counts cycles until the event shows, giving up after lim cycles.
  task cyc(input int sel, input int lim, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge clk_in);
      #1;
      cnt++;
    end
    while (mon[sel] !== 1'b1 && cnt < lim);
    // A limit that runs out without the event counts as a mismatch.
    chk(mon[sel], 1'b1);
  endtask : cyc

  task summarize;
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  initial
  begin
    // The run spans about 33300 cycles, mostly waiting on the time base tap.
    #(50000 * 100);
    errors++;
    summarize();
  end

  initial
  begin
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(SC2_ADDR, 8'h80);
    rd(SC1_ADDR, 8'h00);
    rd(8'h3a, 8'h00);
    wr(SC1_ADDR, 8'h2c);
    rd(SC1_ADDR, 8'h0c);
    // States must walk 0..3 without a gap, one clock each.
    @(posedge clk_in);
    #1;
    st = cpu_state_out;
    for (int i = 1; i < 9; i++)
    begin
      @(posedge clk_in);
      #1;
      chk(cpu_state_out, 2'(st + i));
    end
    m = 0;
    for (int i = 0; i < 30; i++)
    begin
      @(posedge clk_in);
      #1;
      m += int'(pre_tick_out === 1'b1);
    end
    chk(m, 10);
    cyc(0, 200, n);
    cyc(0, 200, n);
    cyc(1, 900, m);
    cyc(1, 900, m);
    chk(m, 4 * n);
    chk(periph_run_out & wdt_run_out & cpu_run_out, 1'b1);
    // Shortest and longest instructions; the first pulse may be stale.
    for (int L = 1; L <= 15; L += 14)
    begin
      @(posedge clk_in);
      len_in <= 4'(L);
      cyc(2, 70, n);
      cyc(2, 70, n);
      cyc(2, 70, n);
      chk(n, 4 * L);
    end
    // Idle entry and wake, once with each master enable value.
    for (int e = 1; e >= 0; e--)
    begin
      @(posedge clk_in);
      ime_in <= 1'(e);
      wr(SC2_ADDR, 8'h10);
      cyc(5, 8, n);
      chk(n < 8, 1'b1);
      chk({periph_run_out, wdt_run_out, osc_run_out}, 3'b101);
      rd(SC2_ADDR, 8'h90);
      @(posedge clk_in);
      delay <= 4'(3 * e);
      raise <= 1'b1;
      @(posedge clk_in);
      raise <= 1'b0;
      cyc(e ? 3 : 4, 16, n);
      chk(n < 16, 1'b1);
      chk({take_irq_out, resume_next_out}, e ? 2'b10 : 2'b01);
      chk({cpu_run_out, cpu_state_out}, {1'b1, ST_S0});
      rd(SC2_ADDR, 8'h80);
    end
    // Stop with level release and the short warm-up.
    wr(SC1_ADDR, 8'hd4);
    cyc(7, 6, n);
    chk({osc_run_out, periph_run_out, cpu_run_out}, 3'b000);
    st = cpu_state_out;
    repeat (5) @(posedge clk_in);
    #1;
    chk(cpu_state_out, st);
    @(posedge clk_in);
    pin_in <= 1'b1;
    cyc(6, 60, n);
    chk(n >= WS && n <= WS + 4, 1'b1);
    // Edge release: a pin held high must not wake the device.
    wr(SC1_ADDR, 8'h90);
    cyc(7, 6, n);
    repeat (8) @(posedge clk_in);
    #1;
    chk(osc_run_out, 1'b0);
    @(posedge clk_in);
    pin_in <= 1'b0;
    @(posedge clk_in);
    pin_in <= 1'b1;
    cyc(6, 80, n);
    chk(n >= WL && n <= WL + 4, 1'b1);
    // Cleared at release, the divider holds 10 after the 40-cycle warm-up,
    // so stage one next rises on count 13, at S3 three machine cycles on.
    cyc(0, 200, m);
    chk(m, 15);
    cyc(0, 200, n);
    chk(n, 16);
    // From count 17 the time base tap waits for count 2**13 - 1.
    cyc(9, 40000, n);
    chk(n, 4 * ((1 << TAP_TB) - 18));
    rd(SC1_ADDR, 8'h10);
    // Watchdog and reset taps lie far beyond this run and must stay quiet.
    chk({wdt_src_out, reset_done_out}, 2'b00);
    summarize();
  end
endmodule : scsc_clock_ctrl_tb_top
